// File: src/fds_pkg.sv
/*
 holds constants and carrier types for the dual-bank fft sequencer.
 assumes a single 25 MHz system clock and an external dual-port memory.
*/
package fds_pkg;
    localparam int unsigned  N_POINTS      = 64;
    localparam logic [7:0]   LAST_ADDR     = 8'h3F;
    localparam logic [8:0]   FIRST_OUT_CYC = 9'h092;  // 146
    localparam logic [8:0]   LAST_OUT_CYC  = 9'h0D1;  // 209
    localparam logic [8:0]   PERIOD_CYC    = 9'h0C0;  // 192
    localparam logic [8:0]   PIPE_CYC      = 9'h011;  // 17
    localparam logic [8:0]   LOAD_OPEN_CYC = 9'h092;  // load window opens with the final pass
    localparam logic [8:0]   WARN_LEAD_CYC = 9'h008;
    localparam logic [8:0]   MODE_CE_CYC   = 9'h0BF;  // one cycle before a new vector starts
    localparam logic [15:0]  IDLE_DATA     = 16'h0000;

    typedef struct packed {
        logic        direction_select;
        logic [1:0]  scale_mode;
    } fds_mode_s;

    typedef struct packed {
        logic [15:0] re;
        logic [15:0] im;
    } fds_sample_s;

    typedef struct packed {
        logic [7:0]  waddr;
        logic [7:0]  raddr;
        logic        we;
        logic        en;
    } fds_mem_s;

    typedef enum logic [1:0] {
        FDS_IDLE,
        FDS_LOAD,
        FDS_UNLOAD,
        FDS_RUN
    } fds_state_e;
endpackage : fds_pkg

// File: src/fds_sequencer.sv
/*
 holds the sequencer: load/unload counter, run timing, result strobe,
 digit-reversed index, load window and mode capture.
 assumes synchronous inputs; butterfly datapath supplies result samples.
*/
`timescale 1ns/1ps
`default_nettype none
module fds_sequencer
    import fds_pkg::*;
(
    input  wire  logic                 clock,
    input  wire  logic                 rst_b,
    input  wire  logic                 dual_bank_mode,
    input  wire  logic                 start,
    input  wire  logic                 load_request,
    input  wire  logic                 unload_request,
    input  wire  fds_pkg::fds_mode_s   mode_in,
    input  wire  fds_pkg::fds_sample_s result_in,
    output var   fds_pkg::fds_mem_s    mem_ctl,
    output var   fds_pkg::fds_sample_s out_bus,
    output var   logic [5:0]           reorder_index,
    output var   logic                 result_strobe,
    output var   logic                 load_window,
    output var   logic                 early_load_warning,
    output var   logic                 input_select,
    output var   logic                 mode_sample,
    output var   fds_pkg::fds_mode_s   mode_active,
    output var   logic [1:0]           pass_count,
    output var   logic                 busy
);
    import fds_pkg::*;

    fds_state_e  state, next_state;
    logic [7:0]  addr, next_addr;
    logic [8:0]  cyc, next_cyc;
    logic        first, next_first;
    fds_mode_s   next_mode_active;
    fds_mem_s    next_mem_ctl;
    fds_sample_s next_out_bus;
    logic [5:0]  next_reorder_index;
    logic        next_result_strobe, next_load_window, next_warn, next_mode_sample;
    logic [1:0]  next_pass_count;
    logic [8:0]  out_first, out_last, out_pos, mode_pos;
    logic        in_out, in_load, in_mode;
    logic [5:0]  k;

    always_comb begin
        out_first = first ? FIRST_OUT_CYC : (FIRST_OUT_CYC - PIPE_CYC);
        out_last  = first ? LAST_OUT_CYC  : (LAST_OUT_CYC - PIPE_CYC);
        in_out    = (state == FDS_RUN) && (cyc >= out_first) && (cyc <= out_last);
        out_pos   = cyc - out_first;
        in_load   = dual_bank_mode && in_out;
        mode_pos  = first ? (MODE_CE_CYC + PIPE_CYC) : MODE_CE_CYC;
        in_mode   = dual_bank_mode && (state == FDS_RUN) && (cyc == mode_pos);
        k         = out_pos[5:0];
    end

    always_comb begin
        next_state         = state;
        next_addr          = addr;
        next_cyc           = cyc;
        next_first         = first;
        next_mode_active   = mode_active;
        next_mem_ctl       = '0;
        next_out_bus       = out_bus;
        next_reorder_index = reorder_index;
        next_result_strobe = 1'b0;
        next_load_window   = 1'b0;
        next_warn          = 1'b0;
        next_mode_sample   = 1'b0;
        next_pass_count    = pass_count;
        if (start) begin
            next_state       = FDS_RUN;
            next_cyc         = 9'h001;
            next_first       = 1'b1;
            next_mode_active = mode_in;
            next_pass_count  = 2'h0;
        end else begin
            case (state)
                FDS_IDLE: begin
                    if (load_request) begin
                        next_state = FDS_LOAD;
                        next_addr  = 8'h00;
                    end else if (unload_request && !dual_bank_mode) begin
                        next_state = FDS_UNLOAD;
                        next_addr  = 8'h00;
                    end
                end
                FDS_LOAD, FDS_UNLOAD: begin
                    next_mem_ctl.en    = 1'b1;
                    next_mem_ctl.we    = (state == FDS_LOAD);
                    next_mem_ctl.waddr = addr;
                    next_mem_ctl.raddr = addr;
                    next_addr          = addr + 8'h01;
                    if (addr == LAST_ADDR) begin
                        next_state = FDS_IDLE;
                    end
                end
                FDS_RUN: begin
                    next_cyc        = cyc + 9'h001;
                    next_mem_ctl.en = 1'b1;
                    next_pass_count = (cyc >= out_first) ? 2'h2 : ((cyc >= (out_first >> 1)) ? 2'h1 : 2'h0);
                    if (in_out) begin
                        next_result_strobe = 1'b1;
                        next_out_bus       = result_in;
                        next_reorder_index = {k[1:0], k[3:2], k[5:4]};
                        next_mem_ctl.we    = 1'b1;
                        next_mem_ctl.waddr = {2'b00, k};
                    end
                    next_load_window = in_load;
                    next_warn = dual_bank_mode && (cyc + WARN_LEAD_CYC >= out_first) && (cyc < out_first);
                    if (in_mode) begin
                        next_mode_sample = 1'b1;
                        next_mode_active = mode_in;
                    end
                    if (cyc == out_last) begin
                        if (dual_bank_mode) begin
                            next_first = 1'b0;
                            next_cyc   = LAST_OUT_CYC - PIPE_CYC - PERIOD_CYC + 9'h001;
                        end else begin
                            next_state = FDS_IDLE;
                        end
                    end
                end
                default: next_state = FDS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state              <= FDS_IDLE;
            addr               <= 8'h00;
            cyc                <= 9'h000;
            first              <= 1'b1;
            mode_active        <= '0;
            mem_ctl            <= '0;
            out_bus            <= '0;
            reorder_index      <= 6'h00;
            result_strobe      <= 1'b0;
            load_window        <= 1'b0;
            early_load_warning <= 1'b0;
            mode_sample        <= 1'b0;
            pass_count         <= 2'h0;
        end else begin
            state              <= next_state;
            addr               <= next_addr;
            cyc                <= next_cyc;
            first              <= next_first;
            mode_active        <= next_mode_active;
            mem_ctl            <= next_mem_ctl;
            out_bus            <= next_out_bus;
            reorder_index      <= next_reorder_index;
            result_strobe      <= next_result_strobe;
            load_window        <= next_load_window;
            early_load_warning <= next_warn;
            mode_sample        <= next_mode_sample;
            pass_count         <= next_pass_count;
        end
    end

    assign input_select = load_window || (mem_ctl.we && !result_strobe);
    assign busy         = (state != FDS_IDLE);

    // helper counter for strobe length
    logic [7:0] strobe_len;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            strobe_len <= 8'h00;
        end else begin
            strobe_len <= result_strobe ? strobe_len + 8'h01 : 8'h00;
        end
    end

    // helper counter for write enable run length
    logic [7:0] we_len;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            we_len <= 8'h00;
        end else begin
            we_len <= mem_ctl.we ? we_len + 8'h01 : 8'h00;
        end
    end

    // helper counter for cycles since start
    logic [8:0] run_age;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            run_age <= 9'h000;
        end else if (start) begin
            run_age <= 9'h001;
        end else if (run_age != 9'h000 && run_age != 9'h1FF) begin
            run_age <= run_age + 9'h001;
        end
    end

    // helper counter for spacing of result vectors
    logic [8:0] rise_gap;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rise_gap <= 9'h000;
        end else if (result_strobe && strobe_len == 8'h00) begin
            rise_gap <= 9'h001;
        end else if (rise_gap != 9'h1FF) begin
            rise_gap <= rise_gap + 9'h001;
        end
    end

    a_first_out: assert property (@(posedge clock) disable iff (!rst_b)
        (run_age == FIRST_OUT_CYC && !start) |-> !result_strobe ##1 result_strobe)
        else $error("first result not at 146 cycles");
    a_last_out: assert property (@(posedge clock) disable iff (!rst_b)
        (run_age == LAST_OUT_CYC + 9'h001 && !start) |-> result_strobe ##1 !result_strobe)
        else $error("last result not at 209 cycles");
    a_strobe_len: assert property (@(posedge clock) disable iff (!rst_b)
        $fell(result_strobe) && !$past(start) |-> $past(strobe_len) == 8'h3F)
        else $error("result strobe not 64 cycles");
    a_load_len: assert property (@(posedge clock) disable iff (!rst_b)
        (state == FDS_LOAD && addr == LAST_ADDR && !start) |=>
            mem_ctl.we && mem_ctl.waddr == LAST_ADDR && we_len == 8'h3F && state == FDS_IDLE)
        else $error("load not 64 cycles");
    a_addr_step: assert property (@(posedge clock) disable iff (!rst_b)
        (state == FDS_LOAD && !start && addr != LAST_ADDR) |=> addr == $past(addr) + 8'h01)
        else $error("address did not step");
    a_index_rev: assert property (@(posedge clock) disable iff (!rst_b)
        result_strobe |-> reorder_index == {strobe_len[1:0], strobe_len[3:2], strobe_len[5:4]})
        else $error("index not digit reversed");
    a_period: assert property (@(posedge clock) disable iff (!rst_b)
        result_strobe && strobe_len == 8'h00 && dual_bank_mode && !first |-> rise_gap == PERIOD_CYC)
        else $error("period broken");
    a_mode_hold: assert property (@(posedge clock) disable iff (!rst_b)
        !start && !in_mode |=> $stable(mode_active))
        else $error("mode changed off strobe");
    a_window_sel: assert property (@(posedge clock) disable iff (!rst_b)
        load_window |-> input_select && result_strobe && dual_bank_mode)
        else $error("select missing in window");

    c_load:   cover property (@(posedge clock) disable iff (!rst_b) state == FDS_LOAD ##64 state == FDS_IDLE);
    c_single: cover property (@(posedge clock) disable iff (!rst_b) $fell(result_strobe) && !dual_bank_mode);
    c_dual:   cover property (@(posedge clock) disable iff (!rst_b) mode_sample && !first);
endmodule : fds_sequencer
`default_nettype wire

// File: dv/fds_host_model.sv
/*
 host side model: result pattern source and reordering result bank.
 assumes sequencer strobe and index are registered on clock.
*/
`timescale 1ns/1ps
`default_nettype none
module fds_host_model
    import fds_pkg::*;
(
    input  wire  logic                 clock,
    input  wire  logic                 rst_b,
    input  wire  logic                 clear_bank,
    input  wire  logic                 result_strobe,
    input  wire  logic [5:0]           reorder_index,
    output var   fds_pkg::fds_sample_s result_in,
    output var   logic [15:0]          port_b_data,
    output var   logic                 bank_full
);
    logic [63:0] written;
    logic [15:0] step;
    assign port_b_data = IDLE_DATA;
    assign result_in   = '{re: step, im: ~step};
    assign bank_full   = &written;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            written <= 64'h0;
            step    <= 16'h0000;
        end else begin
            step <= step + 16'h0001;
            if (clear_bank) written <= 64'h0;
            else if (result_strobe) written[reorder_index] <= 1'b1;
        end
    end
endmodule : fds_host_model
`default_nettype wire

// File: dv/fds_sequencer_tb_top.sv
/*
 testbench: load and run sequences in both bank modes, unload sequence in single bank mode.
 assumes fds_pkg and fds_sequencer compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module fds_sequencer_tb_top;
    import fds_pkg::*;
    logic        clock, rst_b, dual_bank_mode, start, load_request, unload_request, clear_bank;
    logic        result_strobe, load_window, early_load_warning, input_select, mode_sample, busy;
    logic        bank_full;
    logic [5:0]  reorder_index;
    logic [1:0]  pass_count;
    logic [15:0] port_b_data;
    fds_mode_s   mode_in, mode_active;
    fds_sample_s result_in, out_bus;
    fds_mem_s    mem_ctl;
    int          fails, comparisons, k, m;

    fds_sequencer i_dut (.clock(clock), .rst_b(rst_b), .dual_bank_mode(dual_bank_mode), .start(start),
        .load_request(load_request), .unload_request(unload_request), .mode_in(mode_in),
        .result_in(result_in), .mem_ctl(mem_ctl), .out_bus(out_bus), .reorder_index(reorder_index),
        .result_strobe(result_strobe), .load_window(load_window), .early_load_warning(early_load_warning),
        .input_select(input_select), .mode_sample(mode_sample), .mode_active(mode_active),
        .pass_count(pass_count), .busy(busy));
    fds_host_model i_host (.clock(clock), .rst_b(rst_b), .clear_bank(clear_bank),
        .result_strobe(result_strobe), .reorder_index(reorder_index), .result_in(result_in),
        .port_b_data(port_b_data), .bank_full(bank_full));

    task automatic close_out;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tick;
        @(posedge clock);
        #1;
    endtask : tick

    task automatic pulse(input int which);
        @(posedge clock);
        if (which == 0) start <= 1'b1;
        else if (which == 1) load_request <= 1'b1;
        else unload_request <= 1'b1;
        @(posedge clock);
        start          <= 1'b0;
        load_request   <= 1'b0;
        unload_request <= 1'b0;
        #1;
    endtask : pulse

    task automatic io_check(input bit rd);
        k = 0;
        while (mem_ctl.en !== 1'b1 && k < 10) begin
            tick();
            k++;
        end
        chk(k, 1);
        for (int i = 0; i < 64; i++) begin
            chk(rd ? mem_ctl.raddr : mem_ctl.waddr, i);
            chk({mem_ctl.we, input_select}, {!rd, !rd});
            tick();
        end
        chk(mem_ctl.en, 0);
    endtask : io_check

    task automatic run_vector(input int exp_k);
        logic [15:0] prev_re;
        prev_re = 16'h0000;
        k = 0;
        while (result_strobe !== 1'b1 && k < 400) begin
            tick();
            k++;
        end
        chk(k, exp_k);
        for (int i = 0; i < 64; i++) begin
            chk(reorder_index, {i[1:0], i[3:2], i[5:4]});
            chk(result_strobe, 1);
            chk(out_bus.re ^ out_bus.im, 16'hFFFF);
            if (i > 0) chk(out_bus.re, 16'(prev_re + 16'h0001));
            prev_re = out_bus.re;
            if (dual_bank_mode) chk({load_window, input_select}, 2'b11);
            tick();
        end
        chk(result_strobe, 0);
        chk(bank_full, 1);
    endtask : run_vector

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial begin
        #(40 * 6000);
        fails++;
        close_out();
    end

    initial begin
        {rst_b, dual_bank_mode, start, load_request, unload_request, clear_bank} = 6'h00;
        mode_in     = 3'h0;
        fails       = 0;
        comparisons = 0;
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        #1;
        chk({busy, result_strobe, mem_ctl}, 0);
        pulse(1);
        io_check(0);
        mode_in <= 3'h5;
        pulse(0);
        chk(mode_active, 3'h5);
        run_vector(146);
        pulse(2);
        io_check(1);
        $display("single bank test done");
        dual_bank_mode <= 1'b1;
        clear_bank     <= 1'b1;
        pulse(1);
        clear_bank <= 1'b0;
        io_check(0);
        pulse(0);
        mode_in <= 3'h2;
        chk(mode_active, 3'h5);
        pulse(2);
        chk({busy, mem_ctl.we, mem_ctl.en}, 3'b101);
        run_vector(144);
        k = 0;
        while (mode_sample !== 1'b1 && k < 300) begin
            tick();
            k++;
        end
        tick();
        chk(mode_active, 3'h2);
        clear_bank <= 1'b1;
        k = 0;
        while (early_load_warning !== 1'b1 && k < 300) begin
            tick();
            k++;
        end
        clear_bank <= 1'b0;
        chk(k, 121);
        m = 0;
        while (load_window !== 1'b1 && m < 20) begin
            tick();
            m++;
        end
        chk(m, 8);
        run_vector(0);
        $display("dual bank test done");
        pulse(0);
        clear_bank <= 1'b1;
        tick();
        clear_bank <= 1'b0;
        run_vector(145);
        $display("restart test done");
        close_out();
    end
endmodule : fds_sequencer_tb_top
`default_nettype wire
